// ==== hw/tcs_top.sv ====
// Transition control sequencer: panel buttons, lever and frame tick in,
// lamps and mixer/keyer control out, registers over APB.
// Assumes panel pins are asynchronous and the lever moves slowly
// compared with pclk, so a two-stage bus synchroniser is adequate.
//
// Our own choices: register access over APB and the placing of the registers.
module tcs_top
    import tcs_pkg::*;
#(
    parameter int DP_WIN = DP_WIN_CYC,
    parameter int DLG_WIN = DLG_WIN_CYC
) (
    input wire logic pclk, // 100 MHz clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error
    input wire logic [NBTN-1:0] btn_in, // Panel buttons, high = held
    input wire logic [3:0] keypad_digit, // Keypad digit value
    input wire logic [7:0] lever_pos, // Lever position
    input wire logic frame_tick, // Video frame pulse
    output logic lamp_bkgd, // Background delegate lamp
    output logic lamp_key1, // Key 1 delegate lamp
    output logic lamp_key2, // Key 2 delegate lamp
    output logic lamp_mix, // Mix type lamp
    output logic lamp_wipe, // Wipe type lamp
    output logic lamp_cut, // Cut lamp, never lit
    output logic lamp_auto, // Auto transition lamp
    output logic lamp_arrow_up, // Lever must move up
    output logic lamp_arrow_dn, // Lever must move down
    output logic lamp_key1_on, // Key 1 on air
    output logic lamp_key2_on, // Key 2 on air
    output logic lamp_key1_over, // Key 1 on top
    output logic lamp_key2_over, // Key 2 on top
    output logic [7:0] on_air_bus, // On-air source select
    output logic [7:0] next_source_bus, // Next source select
    output logic [7:0] trans_progress, // Progress 0..255
    output logic trans_bkgd, // Background in transition
    output logic trans_key1, // Key 1 in transition
    output logic trans_key2, // Key 2 in transition
    output logic trans_wipe, // Pattern edge, else crossfade
    output logic [1:0] keyer_route, // 0 none, 1 keyer 1, 2 keyer 2
    output logic pattern_to_wipe, // Pattern and matte to wipe
    output logic [7:0] rate_display, // Stored rate in frames
    output logic [15:0] knob_value, // Soft knob value
    output logic [1:0] menu_level, // Menu depth
    output logic [2:0] menu_id, // Open menu
    output logic double_press_menu_open // Menu open pulse
);
    // Windows below two cycles cannot be counted down
    if (DP_WIN < 2 || DLG_WIN < 2) begin : g_win_check
        $error("tcs_top: windows must be at least two cycles");
    end

    logic [NBTN-1:0] btn_s1_reg, btn_s2_reg, btn_d_reg;
    logic [3:0] dig_s1_reg, dig_s2_reg;
    logic [7:0] lev_s1_reg, lev_s2_reg, lev_prev_reg;
    logic tick_s1_reg, tick_s2_reg, tick_d_reg;
    logic [NBTN-1:0] press;
    logic tick_p;

    // Input synchronisers; stage one never feeds logic, only stage two and the delayed copies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_s1_reg <= '0;
            btn_s2_reg <= '0;
            btn_d_reg <= '0;
            dig_s1_reg <= 4'h0;
            dig_s2_reg <= 4'h0;
            lev_s1_reg <= 8'h00;
            lev_s2_reg <= 8'h00;
            lev_prev_reg <= 8'h00;
            tick_s1_reg <= 1'b0;
            tick_s2_reg <= 1'b0;
            tick_d_reg <= 1'b0;
        end else begin
            btn_s1_reg <= btn_in;
            btn_s2_reg <= btn_s1_reg;
            btn_d_reg <= btn_s2_reg;
            dig_s1_reg <= keypad_digit;
            dig_s2_reg <= dig_s1_reg;
            lev_s1_reg <= lever_pos;
            lev_s2_reg <= lev_s1_reg;
            lev_prev_reg <= lev_s2_reg;
            tick_s1_reg <= frame_tick;
            tick_s2_reg <= tick_s1_reg;
            tick_d_reg <= tick_s2_reg;
        end
    end
    assign press = btn_s2_reg & ~btn_d_reg;
    assign tick_p = tick_s2_reg & ~tick_d_reg;

    tcs_state_t state_reg;
    logic [7:0] prog_reg, sub_reg, err_reg, rate_reg;
    logic [2:0] dlg_reg;
    logic [1:0] typ_reg;
    logic lev_dir_reg, lev_last_reg, lev_lock_reg;
    logic [31:0] dlg_cnt_reg;
    logic key1_on_reg, key2_on_reg, key_pri_reg;
    logic [7:0] on_src_reg, nx_src_reg;
    logic [7:0] lev_map;
    logic at_limit, lev_moved, lev_take, step_inc, done_w, swap_w;
    logic wr_en;

    assign wr_en = psel & penable & pwrite & pready;
    assign lev_map = lev_dir_reg ? (PROG_MAX - lev_s2_reg) : lev_s2_reg;
    assign at_limit = (lev_s2_reg == 8'h00) || (lev_s2_reg == PROG_MAX);
    assign lev_moved = lev_s2_reg != lev_prev_reg;
    assign lev_take = !at_limit && !lev_lock_reg && lev_moved &&
                      (lev_map >= prog_reg);
    assign step_inc = (state_reg == ST_AUTO) && (sub_reg != 8'h00) &&
                      ({1'b0, err_reg} + 9'h001 >= {1'b0, rate_reg});
    assign done_w = ((state_reg == ST_IDLE) && press[B_CUT]) ||
        ((state_reg == ST_AUTO) && !press[B_CUT] && step_inc &&
         (prog_reg == PROG_MAX - 8'h01)) ||
        ((state_reg == ST_LEVER) && !press[B_CUT] &&
         (lev_map == PROG_MAX));
    assign swap_w = (state_reg != ST_IDLE) && press[B_CUT];

    // Transition sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            prog_reg <= 8'h00;
            lev_dir_reg <= 1'b0;
            lev_lock_reg <= 1'b0;
            lev_last_reg <= 1'b0;
        end else begin
            if (at_limit) begin
                lev_last_reg <= lev_s2_reg == PROG_MAX;
                lev_lock_reg <= 1'b0;
            end
            if (done_w) begin
                state_reg <= ST_IDLE;
                prog_reg <= 8'h00;
            end else if (swap_w) begin
                prog_reg <= PROG_MAX - prog_reg;
                lev_dir_reg <= ~lev_dir_reg;
            end else begin
                unique case (state_reg)
                    ST_IDLE: begin
                        if (press[B_AUTO]) begin
                            state_reg <= ST_AUTO;
                        end else if (!at_limit && !lev_lock_reg) begin
                            state_reg <= ST_LEVER;
                            lev_dir_reg <= lev_last_reg;
                        end
                    end
                    ST_AUTO, ST_PAUSE: begin
                        if (lev_take) begin
                            state_reg <= ST_LEVER;
                            lev_dir_reg <= lev_last_reg;
                        end else if (press[B_AUTO]) begin
                            state_reg <= (state_reg == ST_AUTO) ?
                                         ST_PAUSE : ST_AUTO;
                        end else if (step_inc) begin
                            prog_reg <= prog_reg + 8'h01;
                        end
                    end
                    ST_LEVER: begin
                        if (press[B_AUTO]) begin
                            state_reg <= ST_AUTO;
                            lev_lock_reg <= 1'b1;
                        end else if (at_limit && lev_map == 8'h00) begin
                            state_reg <= ST_IDLE;
                            prog_reg <= 8'h00;
                        end else begin
                            prog_reg <= lev_map;
                        end
                    end
                endcase
            end
        end
    end

    // Step spreader: 255 cycles per tick, so frames must be further apart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_reg <= 8'h00;
            err_reg <= 8'h00;
        end else if (state_reg != ST_AUTO && state_reg != ST_PAUSE) begin
            sub_reg <= 8'h00;
            err_reg <= 8'h00;
        end else if (state_reg == ST_AUTO && tick_p) begin
            sub_reg <= PROG_MAX;
        end else if (state_reg == ST_AUTO && sub_reg != 8'h00) begin
            sub_reg <= sub_reg - 8'h01;
            err_reg <= step_inc ? 8'h00 : err_reg + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dlg_reg <= 3'b001;
            dlg_cnt_reg <= 32'h0000_0000;
        end else if (state_reg == ST_IDLE && |press[B_KEY2:B_BKGD]) begin
            dlg_reg <= (dlg_cnt_reg != 32'h0000_0000) ?
                       (dlg_reg | press[B_KEY2:B_BKGD]) :
                       press[B_KEY2:B_BKGD];
            dlg_cnt_reg <= 32'(DLG_WIN);
        end else if (dlg_cnt_reg != 32'h0000_0000) begin
            dlg_cnt_reg <= dlg_cnt_reg - 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            typ_reg <= 2'b01;
        end else if (state_reg == ST_IDLE && press[B_WIPE]) begin
            typ_reg <= 2'b10;
        end else if (state_reg == ST_IDLE && press[B_MIX]) begin
            typ_reg <= 2'b01;
        end
    end

    // On-air layer state; completion beats a same-cycle bus write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key1_on_reg <= 1'b0;
            key2_on_reg <= 1'b0;
            on_src_reg <= 8'h00;
            nx_src_reg <= 8'h00;
            key_pri_reg <= 1'b0;
        end else begin
            if (wr_en && paddr == OFF_CTRL) begin
                key_pri_reg <= pwdata[0];
            end
            if (done_w || swap_w) begin
                key1_on_reg <= key1_on_reg ^ dlg_reg[1];
                key2_on_reg <= key2_on_reg ^ dlg_reg[2];
                if (dlg_reg[0]) begin
                    on_src_reg <= nx_src_reg;
                    nx_src_reg <= on_src_reg;
                end
            end else if (wr_en && paddr == OFF_SRC) begin
                nx_src_reg <= pwdata[7:0];
                on_src_reg <= pwdata[15:8];
            end
        end
    end

    logic [3:0] last_btn_reg;
    logic [31:0] dp_cnt_reg;
    logic [3:0] dp_id;
    logic dp_hit;
    logic [1:0] lvl_reg;
    logic [2:0] mid_reg;
    logic double_press_menu_open_reg;
    tcs_ent_t ent_reg;
    logic [15:0] ent_val_reg, knob_reg;
    logic ent_neg_reg;

    // Lowest button that can be double pressed
    always_comb begin
        dp_id = 4'hF;
        if (press[B_KEY1]) dp_id = 4'(B_KEY1);
        else if (press[B_KEY2]) dp_id = 4'(B_KEY2);
        else if (press[B_WIPE]) dp_id = 4'(B_WIPE);
        else if (press[B_SOFT]) dp_id = 4'(B_SOFT);
    end
    assign dp_hit = (dp_id != 4'hF) && (dp_id == last_btn_reg) &&
                    (dp_cnt_reg != 32'h0000_0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_btn_reg <= 4'hF;
            dp_cnt_reg <= 32'h0000_0000;
        end else if (dp_hit) begin
            last_btn_reg <= 4'hF;
            dp_cnt_reg <= 32'h0000_0000;
        end else if (dp_id != 4'hF) begin
            last_btn_reg <= dp_id;
            dp_cnt_reg <= 32'(DP_WIN);
        end else if (dp_cnt_reg != 32'h0000_0000) begin
            dp_cnt_reg <= dp_cnt_reg - 32'h0000_0001;
        end
    end

    // Menu level and identity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_reg <= 2'h0;
            mid_reg <= MENU_NONE;
            double_press_menu_open_reg <= 1'b0;
        end else begin
            double_press_menu_open_reg <= dp_hit && dp_id != 4'(B_SOFT);
            if (dp_hit && dp_id != 4'(B_SOFT)) begin
                lvl_reg <= 2'h1;
                mid_reg <= (dp_id == 4'(B_WIPE)) ? MENU_WIPE : MENU_KEYER;
            end else if (press[B_EXIT] && lvl_reg != 2'h0) begin
                lvl_reg <= lvl_reg - 2'h1;
                if (lvl_reg == 2'h1) mid_reg <= MENU_NONE;
            end
        end
    end

    // Keypad entry, rate and knob commit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ent_reg <= ENT_NONE;
            ent_val_reg <= 16'h0000;
            ent_neg_reg <= 1'b0;
            rate_reg <= RATE_RST;
            knob_reg <= KNOB_DEF;
        end else if (dp_hit && dp_id == 4'(B_SOFT)) begin
            knob_reg <= KNOB_DEF;
            ent_reg <= ENT_NONE;
        end else if (press[B_RATE] || press[B_SOFT]) begin
            ent_reg <= press[B_RATE] ? ENT_RATE : ENT_KNOB;
            ent_val_reg <= 16'h0000;
            ent_neg_reg <= 1'b0;
        end else if (ent_reg != ENT_NONE && press[B_DIGIT]) begin
            ent_val_reg <= (ent_val_reg << 3) + (ent_val_reg << 1) +
                           {12'h000, dig_s2_reg};
        end else if (ent_reg == ENT_KNOB && press[B_SIGN] &&
                     ent_val_reg != 16'h0000) begin
            ent_neg_reg <= ~ent_neg_reg;
        end else if (ent_reg != ENT_NONE && press[B_ENTER]) begin
            ent_reg <= ENT_NONE;
            if (ent_reg == ENT_RATE && ent_val_reg != 16'h0000 &&
                ent_val_reg <= {8'h00, PROG_MAX}) begin
                rate_reg <= ent_val_reg[7:0];
            end
            if (ent_reg == ENT_KNOB) begin
                knob_reg <= ent_neg_reg ? (16'h0000 - ent_val_reg) :
                            ent_val_reg;
            end
        end else if (wr_en && paddr == OFF_RATE && pwdata[7:0] != 8'h00) begin
            rate_reg <= pwdata[7:0];
        end else if (wr_en && paddr == OFF_KNOB) begin
            knob_reg <= pwdata[15:0];
        end
    end

    // Registered lamps and mixer controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_auto <= 1'b0;
            lamp_arrow_up <= 1'b0;
            lamp_arrow_dn <= 1'b0;
            lamp_key1_over <= 1'b0;
            lamp_key2_over <= 1'b0;
            trans_bkgd <= 1'b0;
            trans_key1 <= 1'b0;
            trans_key2 <= 1'b0;
            keyer_route <= 2'h0;
        end else begin
            lamp_auto <= state_reg == ST_AUTO || state_reg == ST_PAUSE;
            lamp_arrow_up <= state_reg == ST_LEVER && !lev_dir_reg;
            lamp_arrow_dn <= state_reg == ST_LEVER && lev_dir_reg;
            lamp_key1_over <= !key_pri_reg;
            lamp_key2_over <= key_pri_reg;
            trans_bkgd <= state_reg != ST_IDLE && dlg_reg[0];
            trans_key1 <= state_reg != ST_IDLE && dlg_reg[1];
            trans_key2 <= state_reg != ST_IDLE && dlg_reg[2];
            keyer_route <= dlg_reg[1] ? 2'h1 : (dlg_reg[2] ? 2'h2 : 2'h0);
        end
    end

    // APB slave: decode in setup, answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    OFF_CTRL: prdata <= {31'h0, key_pri_reg};
                    OFF_SRC: prdata <= {16'h0000, on_src_reg, nx_src_reg};
                    OFF_RATE: prdata <= {24'h00_0000, rate_reg};
                    OFF_STAT: prdata <= {8'h00, typ_reg[1], dlg_reg,
                                         key2_on_reg, key1_on_reg,
                                         state_reg, prog_reg, 8'h00};
                    OFF_KNOB: prdata <= {16'h0000, knob_reg};
                    OFF_MENU: prdata <= {27'h000_0000, mid_reg, lvl_reg};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    assign lamp_bkgd = dlg_reg[0];
    assign lamp_key1 = dlg_reg[1];
    assign lamp_key2 = dlg_reg[2];
    assign lamp_mix = typ_reg[0];
    assign lamp_wipe = typ_reg[1];
    assign lamp_cut = 1'b0;
    assign lamp_key1_on = key1_on_reg;
    assign lamp_key2_on = key2_on_reg;
    assign on_air_bus = on_src_reg;
    assign next_source_bus = nx_src_reg;
    assign trans_progress = prog_reg;
    assign trans_wipe = typ_reg[1];
    assign pattern_to_wipe = typ_reg[1];
    assign rate_display = rate_reg;
    assign knob_value = knob_reg;
    assign menu_level = lvl_reg;
    assign menu_id = mid_reg;
    assign double_press_menu_open = double_press_menu_open_reg;
endmodule : tcs_top

// ==== hw/tcs_pkg.sv ====
// Constants, register map and state codes for the transition sequencer.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
package tcs_pkg;
    localparam int CLK_MHZ = 100;
    localparam int DP_WIN_MS = 300;
    localparam int DP_WIN_CYC = DP_WIN_MS * 1000 * CLK_MHZ;
    localparam int DLG_WIN_MS = 50;
    localparam int DLG_WIN_CYC = DLG_WIN_MS * 1000 * CLK_MHZ;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SRC = 8'h04;
    localparam logic [7:0] OFF_RATE = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_KNOB = 8'h10;
    localparam logic [7:0] OFF_MENU = 8'h14;
    // Reset values and progress full scale
    localparam logic [7:0] RATE_RST = 8'h1E;
    localparam logic [15:0] KNOB_DEF = 16'h0000;
    localparam logic [7:0] PROG_MAX = 8'hFF;
    // Panel button indices
    localparam int B_BKGD = 0;
    localparam int B_KEY1 = 1;
    localparam int B_KEY2 = 2;
    localparam int B_MIX = 3;
    localparam int B_WIPE = 4;
    localparam int B_CUT = 5;
    localparam int B_AUTO = 6;
    localparam int B_RATE = 7;
    localparam int B_ENTER = 8;
    localparam int B_SIGN = 9;
    localparam int B_EXIT = 10;
    localparam int B_SOFT = 11;
    localparam int B_DIGIT = 12;
    localparam int NBTN = 13;
    // Menu identifiers
    localparam logic [2:0] MENU_NONE = 3'h0;
    localparam logic [2:0] MENU_KEYER = 3'h1;
    localparam logic [2:0] MENU_WIPE = 3'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_AUTO = 2'b01,
        ST_PAUSE = 2'b10,
        ST_LEVER = 2'b11
    } tcs_state_t;
    typedef enum logic [1:0] {
        ENT_NONE = 2'b00,
        ENT_RATE = 2'b01,
        ENT_KNOB = 2'b10
    } tcs_ent_t;
endpackage : tcs_pkg

// ==== dv/tcs_checker.sv ====
// Port checker for tcs_top: lamp, route and menu relations.
// Assumes bind to tcs_top; every input is one of its ports.
module tcs_checker (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic lamp_bkgd, // Bkgd lamp
    input wire logic lamp_key1, // Key 1 lamp
    input wire logic lamp_key2, // Key 2 lamp
    input wire logic lamp_mix, // Mix lamp
    input wire logic lamp_wipe, // Wipe lamp
    input wire logic lamp_cut, // Cut lamp
    input wire logic lamp_key1_over, // Key 1 top
    input wire logic lamp_key2_over, // Key 2 top
    input wire logic [7:0] trans_progress, // Progress
    input wire logic trans_bkgd, // Bkgd moving
    input wire logic trans_key1, // Key 1 moving
    input wire logic trans_key2, // Key 2 moving
    input wire logic trans_wipe, // Edge mode
    input wire logic pattern_to_wipe, // Wipe route
    input wire logic [1:0] keyer_route, // Keyer route
    input wire logic [1:0] menu_level, // Menu depth
    input wire logic double_press_menu_open // Menu pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_cut_dark; lamp_cut == 1'b0; endproperty
    a_cut_dark: assert property (p_cut_dark) else $error("cut lit");
    property p_type_one; lamp_mix != lamp_wipe; endproperty
    a_type_one: assert property (p_type_one) else $error("type");
    property p_wipe_route; trans_wipe == lamp_wipe &&
        pattern_to_wipe == lamp_wipe; endproperty
    a_wipe_route: assert property (p_wipe_route) else $error("wipe");
    // one key on top; first edge lets the flop load
    property p_over_one; $past(presetn) |->
        lamp_key1_over != lamp_key2_over; endproperty
    a_over_one: assert property (p_over_one) else $error("over");
    property p_route_k1; lamp_key1 && $past(lamp_key1) |->
        keyer_route == 2'd1; endproperty
    a_route_k1: assert property (p_route_k1) else $error("route");
    property p_deleg_lock; $past(trans_progress) != 8'h00 &&
        trans_progress != 8'h00 |->
        $stable({lamp_bkgd, lamp_key1, lamp_key2}); endproperty
    a_deleg_lock: assert property (p_deleg_lock) else $error("lock");
    property p_trans_set; $past(trans_progress) != 8'h00 &&
        trans_progress != 8'h00 |-> trans_bkgd == lamp_bkgd &&
        trans_key1 == lamp_key1 && trans_key2 == lamp_key2; endproperty
    a_trans_set: assert property (p_trans_set) else $error("layers");
    property p_dp_menu; double_press_menu_open |=>
        !double_press_menu_open && menu_level == 2'd1; endproperty
    a_dp_menu: assert property (p_dp_menu) else $error("menu");
endmodule : tcs_checker
bind tcs_top tcs_checker chk_u (
    .pclk(pclk), .presetn(presetn), .lamp_bkgd(lamp_bkgd),
    .lamp_key1(lamp_key1), .lamp_key2(lamp_key2), .lamp_mix(lamp_mix),
    .lamp_wipe(lamp_wipe), .lamp_cut(lamp_cut),
    .lamp_key1_over(lamp_key1_over), .lamp_key2_over(lamp_key2_over),
    .trans_progress(trans_progress), .trans_bkgd(trans_bkgd),
    .trans_key1(trans_key1), .trans_key2(trans_key2),
    .trans_wipe(trans_wipe), .pattern_to_wipe(pattern_to_wipe),
    .keyer_route(keyer_route), .menu_level(menu_level),
    .double_press_menu_open(double_press_menu_open)
);

// ==== dv/tcs_panel.sv ====
// Panel model: buttons, keypad, lever and frame pulses.
// Assumes the bench clock; pins move just after a rising edge.
module tcs_panel
    import tcs_pkg::*;
(
    input wire logic pclk, // Clock
    output logic [NBTN-1:0] btn_in, // Buttons held
    output logic [3:0] keypad_digit, // Keypad digit
    output logic [7:0] lever_pos, // Lever position
    output logic frame_tick // Frame pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle panel from time zero
    initial begin
        btn_in = '0;
        keypad_digit = 4'h0;
        lever_pos = 8'h00;
        frame_tick = 1'b0;
    end
    // Held four cycles: the sync alone costs two
    task automatic press(input logic [NBTN-1:0] m);
        @(posedge pclk) btn_in <= m;
        repeat (4) @(posedge pclk);
        btn_in <= '0;
        repeat (5) @(posedge pclk);
    endtask : press
    // Digit settles before its strobe rises
    task automatic digit(input logic [3:0] d);
        @(posedge pclk) keypad_digit <= d;
        press(NBTN'(1) << B_DIGIT);
    endtask : digit
    // One frame; the step spreader needs 255 cycles after each tick
    task automatic frame();
        @(posedge pclk) frame_tick <= 1'b1;
        repeat (3) @(posedge pclk);
        frame_tick <= 1'b0;
        repeat (260) @(posedge pclk);
    endtask : frame
    // Lever jumps, then waits out the sync
    task automatic lever(input logic [7:0] v);
        @(posedge pclk) lever_pos <= v;
        repeat (8) @(posedge pclk);
    endtask : lever
endmodule : tcs_panel

// ==== dv/tb_top.sv ====
// Bench for tcs_top: APB tasks plus panel sequences.
// Assumes tcs_panel at the panel pins and the bound checker.
module tb_top
    import tcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_tick;
    logic lamp_bkgd, lamp_key1, lamp_key2, lamp_mix, lamp_wipe, lamp_cut;
    logic lamp_auto, lamp_arrow_up, lamp_arrow_dn, lamp_key1_on;
    logic lamp_key2_on, lamp_key1_over, lamp_key2_over, trans_bkgd;
    logic trans_key1, trans_key2, trans_wipe, pattern_to_wipe, er;
    logic double_press_menu_open;
    logic [31:0] prdata, pwdata, rd;
    logic [7:0] paddr, on_air_bus, next_source_bus, trans_progress, p;
    logic [7:0] rate_display, lever_pos;
    logic [1:0] keyer_route, menu_level;
    logic [2:0] menu_id;
    logic [3:0] keypad_digit;
    logic [15:0] knob_value;
    logic [NBTN-1:0] btn_in;
    int num_errors = 0;
    int comparisons = 0;
    // Short windows keep the run brief
    tcs_top #(.DP_WIN(20), .DLG_WIN(10)) dut_u (.*);
    tcs_panel panel_u (
        .pclk(pclk), .btn_in(btn_in), .keypad_digit(keypad_digit),
        .lever_pos(lever_pos), .frame_tick(frame_tick)
    );
    always #5 pclk = ~pclk;
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    // One APB transfer; read data and error land in rd and er
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic finish_test();
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // Far beyond the roughly 1,600 cycles the sequence needs
    initial begin
        #200_000;
        num_errors++;
        finish_test();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("bkgd", lamp_bkgd, 1);
        chk("mix", lamp_mix, 1);
        apb(0, 8'h18, 0);
        chk("err", er, 1);
        apb(1, OFF_SRC, 32'h0000_0201);
        panel_u.press(13'h0020);
        chk("air", {on_air_bus, next_source_bus}, 16'h0102);
        panel_u.press(13'h0006);
        chk("deleg", {lamp_bkgd, lamp_key1, lamp_key2}, 3'b011);
        chk("route", keyer_route, 1);
        panel_u.press(13'h0020);
        chk("keys", {lamp_key1_on, lamp_key2_on, on_air_bus}, 10'h301);
        apb(1, OFF_CTRL, 1);
        repeat (2) @(posedge pclk);
        chk("over", {lamp_key1_over, lamp_key2_over}, 2'b01);
        panel_u.press(13'h0080);
        panel_u.digit(4'h4);
        panel_u.press(13'h0100);
        chk("rate", rate_display, 4);
        apb(0, OFF_RATE, 0);
        chk("rate reg", rd, 4);
        panel_u.press(13'h0001);
        chk("key1", lamp_key1, 0);
        panel_u.press(13'h0040);
        chk("auto", lamp_auto, 1);
        repeat (2) panel_u.frame();
        chk("moving", trans_progress == 8'h00, 0);
        panel_u.press(13'h0040);
        p = trans_progress;
        panel_u.frame();
        chk("pause", trans_progress, p);
        panel_u.press(13'h0040);
        panel_u.frame();
        chk("third", lamp_auto, 1);
        panel_u.frame();
        chk("done", {lamp_auto, trans_progress}, 0);
        chk("swap", {on_air_bus, next_source_bus}, 16'h0201);
        panel_u.press(13'h0010);
        chk("wipe", {lamp_wipe, lamp_mix}, 2'b10);
        chk("edge", {trans_wipe, pattern_to_wipe}, 2'b11);
        panel_u.press(13'h0010);
        chk("menu", {menu_level, menu_id}, {2'd1, MENU_WIPE});
        panel_u.press(13'h0400);
        chk("exit", {menu_level, menu_id}, {2'd0, MENU_NONE});
        panel_u.press(13'h0800);
        panel_u.digit(4'h5);
        panel_u.press(13'h0200);
        panel_u.press(13'h0100);
        chk("knob", knob_value, 16'hFFFB);
        repeat (2) panel_u.press(13'h0800);
        chk("deflt", knob_value, KNOB_DEF);
        panel_u.lever(8'd100);
        chk("arrow", {lamp_arrow_up, lamp_arrow_dn}, 2'b10);
        chk("lev", trans_progress, 100);
        panel_u.lever(8'd60);
        chk("back", trans_progress, 60);
        panel_u.press(13'h0020);
        chk("cut", {on_air_bus, next_source_bus}, 16'h0102);
        chk("mirror", trans_progress, 195);
        finish_test();
    end
endmodule : tb_top
